// >>> rtl/pfs_top.sv
/*
 pfs_top: special function selector for port pins 1..5.
 assumes synchronous inputs on CLK_I; pad drivers resolve the three pin signals outside.
*/
// How it works
// - each pin takes a function code; general input and output are included
// - transmit-burst indication only on pin 1, code 9, off after reset
// - burst output rises before first slot, falls ~5 us after last slot
// - supply enable defaults to pin 2; code 3 puts it on pins 1,3,4,5 once pin 2 gives it up
// - supply enable output follows gnss control setting, default 0
// - data-ready only on pin 3, code 4
// - data-ready wakes only if control 1 and pin setting 16; else pulled-down tri-state
// - time-sync only on pin 4, code 5; drives sync if control 1, setting 32
// - card detect only on pin 5, default code 7, input with pull-down
// - every card line change raises a notification pulse while pin 5 holds code 7
// - hot insertion handling off until configuration item 50 enables it
// - network status on pins 1..5 by code 2, one pin, none at reset
// - network pin repeats home/visitor blink patterns
// - network pin low with no service, high during a call
`timescale 1ns/1ps
module pfs_top (
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic CMD_VALID_I,
   input wire logic [pfs_pkg::PIN_W-1:0] CMD_PIN_I,
   input wire logic [pfs_pkg::CODE_W-1:0] CMD_CODE_I,
   output logic CMD_ACCEPT_O,
   output logic CMD_REJECT_O,
   input wire logic GNSS_CTRL_I,
   input wire logic [pfs_pkg::GSET_W-1:0] GNSS_PIN_SET_I,
   input wire logic CFG_VALID_I,
   input wire logic [7:0] CFG_ITEM_I,
   input wire logic CFG_VALUE_I,
   input wire logic TX_WINDOW_I,
   input wire logic SYNC_PULSE_I,
   input wire pfs_pkg::pfs_net_t NET_STATE_I,
   input wire logic [pfs_pkg::NPINS-1:0] GP_OUT_VAL_I,
   input wire logic [pfs_pkg::NPINS-1:0] PIN_IN_I,
   output logic [pfs_pkg::NPINS-1:0] PIN_OUT_O,
   output logic [pfs_pkg::NPINS-1:0] PIN_OE_O,
   output logic [pfs_pkg::NPINS-1:0] PIN_PULLDOWN_O,
   output logic [pfs_pkg::NPINS-1:0] GP_IN_O,
   output logic GNSS_WAKE_O,
   output logic CARD_PRESENT_O,
   output logic CARD_EVENT_O,
   output logic HOTPLUG_EN_O
);
   import pfs_pkg::*;

   // -------------------------------------------
   // function code table
   // -------------------------------------------
   logic [CODE_W-1:0] code [NPINS];
   logic [CODE_W-1:0] next_code [NPINS];
   logic accept, reject;
   logic hot, next_hot;

   function automatic logic allowed(input logic [2:0] p, input logic [7:0] c);
      logic ok;
      ok = 1'b0;
      case (c)
         FN_OUTPUT, FN_INPUT, FN_PAD_OFF, FN_NETSTAT: ok = 1'b1;
         FN_GNSS_SUPPLY: ok = 1'b1;
         FN_TX_BURST: ok = (p == PIN1);
         FN_GNSS_READY: ok = (p == PIN3);
         FN_TIME_SYNC: ok = (p == PIN4);
         FN_CARD_DETECT: ok = (p == PIN5);
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : allowed

   always_comb begin
      logic taken;
      taken = 1'b0;
      for (int i = 0; i < NPINS; i++) begin
         next_code[i] = code[i];
         // network status and supply enable can be held by one pin only
         if ((CMD_CODE_I == FN_NETSTAT || CMD_CODE_I == FN_GNSS_SUPPLY) &&
             code[i] == CMD_CODE_I && i != int'(CMD_PIN_I))
            taken = 1'b1;
      end
      accept = CMD_VALID_I && (int'(CMD_PIN_I) < NPINS) && allowed(CMD_PIN_I, CMD_CODE_I) && !taken;
      reject = CMD_VALID_I && !accept;
      if (accept)
         next_code[CMD_PIN_I] = CMD_CODE_I;
      next_hot = hot;
      if (CFG_VALID_I && CFG_ITEM_I == CFG_HOTPLUG_ITEM)
         next_hot = CFG_VALUE_I;
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         code[PIN1] <= FN_PAD_OFF;
         code[PIN2] <= FN_GNSS_SUPPLY;
         code[PIN3] <= FN_GNSS_READY;
         code[PIN4] <= FN_TIME_SYNC;
         code[PIN5] <= FN_CARD_DETECT;
         hot <= 1'b0;
         CMD_ACCEPT_O <= 1'b0;
         CMD_REJECT_O <= 1'b0;
      end else begin
         code <= next_code;
         hot <= next_hot;
         CMD_ACCEPT_O <= accept;
         CMD_REJECT_O <= reject;
      end
   end

   // -------------------------------------------
   // transmit burst trailing stretch
   // -------------------------------------------
   // the ~10 us lead is the radio's job: TX_WINDOW_I is raised early
   localparam int TR_W = 8;
   logic [TR_W-1:0] trail, next_trail;
   logic burst;

   always_comb begin
      if (TX_WINDOW_I)
         next_trail = TR_W'(TX_TRAIL_CYC);
      else if (trail != '0)
         next_trail = trail - TR_W'(1);
      else
         next_trail = '0;
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I)
         trail <= '0;
      else
         trail <= next_trail;
   end

   assign burst = TX_WINDOW_I || (trail != '0);

   // -------------------------------------------
   // network blink generator
   // -------------------------------------------
   pfs_blink_if blk ();
   assign blk.state = NET_STATE_I;

   pfs_blink u_blink (
      .clk_i(CLK_I),
      .rst_i(SYS_RST_I),
      .bl(blk.gen)
   );

   // -------------------------------------------
   // card detect change events
   // -------------------------------------------
   logic card, next_card, card_evt, next_card_evt;

   always_comb begin
      next_card = (code[PIN5] == FN_CARD_DETECT) ? PIN_IN_I[PIN5] : card;
      next_card_evt = (code[PIN5] == FN_CARD_DETECT) && (PIN_IN_I[PIN5] != card);
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         card <= 1'b0;
         card_evt <= 1'b0;
      end else begin
         card <= next_card;
         card_evt <= next_card_evt;
      end
   end

   // -------------------------------------------
   // pad drive
   // -------------------------------------------
   logic [NPINS-1:0] next_out, next_oe, next_pd, next_gpin;
   logic next_wake;
   logic gready, gsync;

   assign gready = GNSS_CTRL_I && (GNSS_PIN_SET_I == GSET_READY);
   assign gsync = GNSS_CTRL_I && (GNSS_PIN_SET_I == GSET_SYNC);

   always_comb begin
      next_wake = 1'b0;
      for (int i = 0; i < NPINS; i++) begin
         next_out[i] = 1'b0;
         next_oe[i] = 1'b0;
         next_pd[i] = 1'b0;
         next_gpin[i] = 1'b0;
         case (code[i])
            FN_OUTPUT: begin
               next_oe[i] = 1'b1;
               next_out[i] = GP_OUT_VAL_I[i];
            end
            FN_INPUT: next_gpin[i] = PIN_IN_I[i];
            FN_NETSTAT: begin
               next_oe[i] = 1'b1;
               next_out[i] = blk.level;
            end
            FN_GNSS_SUPPLY: begin
               next_oe[i] = 1'b1;
               next_out[i] = GNSS_CTRL_I;
            end
            FN_GNSS_READY: begin
               next_pd[i] = !gready;
               next_wake = gready && PIN_IN_I[i];
            end
            FN_TIME_SYNC: begin
               next_oe[i] = 1'b1;
               next_out[i] = gsync && SYNC_PULSE_I;
            end
            FN_CARD_DETECT: next_pd[i] = 1'b1;
            FN_TX_BURST: begin
               next_oe[i] = 1'b1;
               next_out[i] = burst;
            end
            default: next_pd[i] = 1'b1;
         endcase
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         PIN_OUT_O <= '0;
         PIN_OE_O <= '0;
         PIN_PULLDOWN_O <= '1;
         GP_IN_O <= '0;
         GNSS_WAKE_O <= 1'b0;
      end else begin
         PIN_OUT_O <= next_out;
         PIN_OE_O <= next_oe;
         PIN_PULLDOWN_O <= next_pd;
         GP_IN_O <= next_gpin;
         GNSS_WAKE_O <= next_wake;
      end
   end

   assign CARD_PRESENT_O = card;
   assign CARD_EVENT_O = card_evt;
   assign HOTPLUG_EN_O = hot;
endmodule : pfs_top

// >>> rtl/pfs_pkg.sv
/*
 pfs_pkg: constants and types for the pin function selector.
 assumes a single 20 MHz clock domain.
*/
package pfs_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   localparam int NPINS = 5;
   localparam int PIN_W = 3;
   localparam int CODE_W = 8;
   localparam int GSET_W = 8;
   // function codes
   localparam logic [7:0] FN_OUTPUT = 8'h00;
   localparam logic [7:0] FN_INPUT = 8'h01;
   localparam logic [7:0] FN_NETSTAT = 8'h02;
   localparam logic [7:0] FN_GNSS_SUPPLY = 8'h03;
   localparam logic [7:0] FN_GNSS_READY = 8'h04;
   localparam logic [7:0] FN_TIME_SYNC = 8'h05;
   localparam logic [7:0] FN_CARD_DETECT = 8'h07;
   localparam logic [7:0] FN_TX_BURST = 8'h09;
   localparam logic [7:0] FN_PAD_OFF = 8'hFF;
   // pin indices, zero based
   localparam logic [2:0] PIN1 = 3'h0;
   localparam logic [2:0] PIN2 = 3'h1;
   localparam logic [2:0] PIN3 = 3'h2;
   localparam logic [2:0] PIN4 = 3'h3;
   localparam logic [2:0] PIN5 = 3'h4;
   localparam logic [7:0] GSET_READY = 8'h10;
   localparam logic [7:0] GSET_SYNC = 8'h20;
   localparam logic [7:0] CFG_HOTPLUG_ITEM = 8'h32;
   // burst guard times
   localparam int unsigned TX_LEAD_US = 10;
   localparam int unsigned TX_TRAIL_US = 5;
   localparam int unsigned TX_TRAIL_CYC = TX_TRAIL_US * (CLK_HZ / 1000000);
   // blink timing
   localparam int unsigned MS_CYC = CLK_HZ / 1000;
   localparam int unsigned T50_MS = 50;
   localparam int unsigned T100_MS = 100;
   localparam int unsigned T2000_MS = 2000;
   localparam int unsigned T50_CYC = T50_MS * MS_CYC;
   localparam int unsigned T100_CYC = T100_MS * MS_CYC;
   localparam int unsigned T2000_CYC = T2000_MS * MS_CYC;
   localparam int TMR_W = 26;
   typedef enum logic [2:0] {
      NS_NONE = 3'h0,
      NS_HOME2G = 3'h1,
      NS_HOME3G = 3'h2,
      NS_VISIT2G = 3'h3,
      NS_VISIT3G = 3'h4,
      NS_CALL = 3'h5
   } pfs_net_t;
endpackage : pfs_pkg

// >>> rtl/pfs_blink_if.sv
/*
 pfs_blink_if: carries network state and the blink level between the top and the blink generator.
 assumes one clock domain.
*/
`timescale 1ns/1ps
interface pfs_blink_if;
   import pfs_pkg::*;
   pfs_net_t state;
   logic level;
   modport ctl (output state, input level);
   modport gen (input state, output level);
endinterface : pfs_blink_if

// >>> rtl/pfs_blink.sv
/*
 pfs_blink: network status blink pattern generator.
 assumes the state input is stable for whole patterns; a change restarts the pattern.
*/
`timescale 1ns/1ps
module pfs_blink (
   input wire logic clk_i,
   input wire logic rst_i,
   pfs_blink_if.gen bl
);
   import pfs_pkg::*;
   // -------------------------------------------
   // phase sequencer: up to four phases, high/low/high/low
   // -------------------------------------------
   logic [1:0] phase, next_phase;
   logic [TMR_W-1:0] tmr, next_tmr;
   logic lvl, next_lvl;
   pfs_net_t last, next_last;
   logic [TMR_W-1:0] len [4];

   always_comb begin
      len[0] = TMR_W'(T100_CYC);
      len[1] = TMR_W'(T2000_CYC);
      len[2] = '0;
      len[3] = '0;
      case (bl.state)
         NS_HOME2G: begin
            len[0] = TMR_W'(T100_CYC);
            len[1] = TMR_W'(T2000_CYC);
         end
         NS_HOME3G, NS_VISIT3G: begin
            len[0] = TMR_W'(T50_CYC);
            len[1] = TMR_W'(T50_CYC);
            len[2] = TMR_W'(T50_CYC);
            len[3] = (bl.state == NS_HOME3G) ? TMR_W'(T2000_CYC) : TMR_W'(T100_CYC);
         end
         NS_VISIT2G: begin
            len[0] = TMR_W'(T100_CYC);
            len[1] = TMR_W'(T100_CYC);
            len[2] = TMR_W'(T100_CYC);
            len[3] = TMR_W'(T2000_CYC);
         end
         default: ;
      endcase
   end

   always_comb begin
      next_last = bl.state;
      next_phase = phase;
      next_tmr = tmr;
      if (bl.state != last) begin
         next_phase = 2'h0;
         next_tmr = '0;
      end else if (tmr + TMR_W'(1) >= len[phase]) begin
         next_tmr = '0;
         // two-phase patterns wrap after phase 1
         next_phase = (phase == 2'h1 && len[2] == '0) ? 2'h0 : phase + 2'h1;
      end else begin
         next_tmr = tmr + TMR_W'(1);
      end
      case (bl.state)
         NS_NONE: next_lvl = 1'b0;
         NS_CALL: next_lvl = 1'b1;
         default: next_lvl = ~next_phase[0];
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase <= 2'h0;
         tmr <= '0;
         lvl <= 1'b0;
         last <= NS_NONE;
      end else begin
         phase <= next_phase;
         tmr <= next_tmr;
         lvl <= next_lvl;
         last <= next_last;
      end
   end

   assign bl.level = lvl;
endmodule : pfs_blink

// >>> verif/pfs_top_chk.sv
/*
 pfs_top_chk: port-level assertions for pfs_top.
 assumes it is bound to pfs_top; one clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
module pfs_top_chk
   import pfs_pkg::*;
(
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic CMD_VALID_I,
   input wire logic [pfs_pkg::PIN_W-1:0] CMD_PIN_I,
   input wire logic [pfs_pkg::CODE_W-1:0] CMD_CODE_I,
   input wire logic CMD_ACCEPT_O,
   input wire logic CMD_REJECT_O,
   input wire logic GNSS_CTRL_I,
   input wire logic [pfs_pkg::GSET_W-1:0] GNSS_PIN_SET_I,
   input wire logic GNSS_WAKE_O,
   input wire logic CARD_PRESENT_O,
   input wire logic CARD_EVENT_O
);
   import pfs_pkg::*;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);
   // ----------------------------------------
   // command answers
   // ----------------------------------------
   AST_ONE_ANSWER: assert property (CMD_VALID_I |=> CMD_ACCEPT_O != CMD_REJECT_O)
      else $error("command not answered by exactly one of accept and reject");
   AST_NO_SPURIOUS: assert property (!CMD_VALID_I |=> !CMD_ACCEPT_O && !CMD_REJECT_O)
      else $error("answer without a request");
   AST_BAD_INDEX: assert property (CMD_VALID_I && CMD_PIN_I > PIN5 |=> CMD_REJECT_O)
      else $error("pin index beyond pin 5 accepted");
   AST_BURST_PIN: assert property (CMD_VALID_I && CMD_CODE_I == FN_TX_BURST && CMD_PIN_I != PIN1
      |=> CMD_REJECT_O)
      else $error("burst indication accepted off pin 1");
   AST_READY_PIN: assert property (CMD_VALID_I && CMD_CODE_I == FN_GNSS_READY && CMD_PIN_I != PIN3
      |=> CMD_REJECT_O)
      else $error("data-ready accepted off pin 3");
   AST_SYNC_PIN: assert property (CMD_VALID_I && CMD_CODE_I == FN_TIME_SYNC && CMD_PIN_I != PIN4
      |=> CMD_REJECT_O)
      else $error("time sync accepted off pin 4");
   AST_CARD_PIN: assert property (CMD_VALID_I && CMD_CODE_I == FN_CARD_DETECT && CMD_PIN_I != PIN5
      |=> CMD_REJECT_O)
      else $error("card detect accepted off pin 5");
   // ----------------------------------------
   // wake and card events
   // ----------------------------------------
   AST_WAKE_GATE: assert property (GNSS_WAKE_O |-> $past(GNSS_CTRL_I) && $past(GNSS_PIN_SET_I) == GSET_READY)
      else $error("wake raised while not enabled");
   AST_CARD_EVENT: assert property (CARD_EVENT_O |-> CARD_PRESENT_O != $past(CARD_PRESENT_O))
      else $error("card event without a level change");
endmodule : pfs_top_chk

// >>> verif/pfs_board_model.sv
/*
 pfs_board_model: board around port pins 1..5: card holder, receiver ready line, pad wires.
 assumes the pad drive of pfs_top; resolves each wire and feeds it back as the pad input.
*/
`timescale 1ns/1ps
module pfs_board_model (
   input wire logic clk_i,
   input wire logic [pfs_pkg::NPINS-1:0] pin_out_i,
   input wire logic [pfs_pkg::NPINS-1:0] pin_oe_i,
   input wire logic [pfs_pkg::NPINS-1:0] pin_pd_i,
   input wire logic card_i,
   input wire logic rdy_i,
   output logic [pfs_pkg::NPINS-1:0] pin_in_o
);
   import pfs_pkg::*;
   logic [NPINS-1:0] last;
   always_comb begin
      for (int i = 0; i < NPINS; i++) begin
         if (pin_oe_i[i]) pin_in_o[i] = pin_out_i[i];
         else if (i == 4) pin_in_o[i] = card_i; // strong pull-up when present, weak pull-down else
         else if (i == 2) pin_in_o[i] = rdy_i;
         else if (pin_pd_i[i]) pin_in_o[i] = 1'b0;
         else pin_in_o[i] = ~last[i]; // floating: a stale level must not look valid
      end
   end
   always_ff @(posedge clk_i) last <= pin_in_o;
endmodule : pfs_board_model

// >>> verif/pfs_top_tb_top.sv
/*
 pfs_top_tb_top: self-checking bench for pfs_top with the board model.
 assumes the 20 MHz clock; blink timing is checked only at pattern start.
*/
`timescale 1ns/1ps
module pfs_top_tb_top;
   import pfs_pkg::*;
   logic clk, rst, vld, acc, rej, gctl, cfg_v, cfg_val, txw, syncp, wake, card_o, cev, hp, card, rdy;
   logic [2:0] cpin;
   logic [7:0] ccode, gset, cfg_item;
   logic [4:0] gpo, pin_in, pin_out, pin_oe, pin_pd, gp_in;
   pfs_net_t net;
   int bad_count, check_count;
   pfs_top u_pfs_top (.CLK_I(clk), .SYS_RST_I(rst), .CMD_VALID_I(vld), .CMD_PIN_I(cpin), .CMD_CODE_I(ccode),
      .CMD_ACCEPT_O(acc), .CMD_REJECT_O(rej), .GNSS_CTRL_I(gctl), .GNSS_PIN_SET_I(gset), .CFG_VALID_I(cfg_v),
      .CFG_ITEM_I(cfg_item), .CFG_VALUE_I(cfg_val), .TX_WINDOW_I(txw), .SYNC_PULSE_I(syncp), .NET_STATE_I(net),
      .GP_OUT_VAL_I(gpo), .PIN_IN_I(pin_in), .PIN_OUT_O(pin_out), .PIN_OE_O(pin_oe), .PIN_PULLDOWN_O(pin_pd),
      .GP_IN_O(gp_in), .GNSS_WAKE_O(wake), .CARD_PRESENT_O(card_o), .CARD_EVENT_O(cev), .HOTPLUG_EN_O(hp));
   pfs_board_model u_pfs_board_model (.clk_i(clk), .pin_out_i(pin_out), .pin_oe_i(pin_oe), .pin_pd_i(pin_pd),
      .card_i(card), .rdy_i(rdy), .pin_in_o(pin_in));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic cmd(input logic [2:0] pin, input logic [7:0] code, input logic ok);
      @(posedge clk);
      vld <= 1'b1;
      cpin <= pin;
      ccode <= code;
      @(posedge clk);
      vld <= 1'b0;
      #1;
      chk(acc, ok);
      chk(rej, ~ok);
   endtask : cmd
   task automatic wait_ev();
      int i;
      // step off the launching edge first, or the pulse of the previous change is read again
      cyc(1);
      for (i = 0; i < 8 && cev !== 1'b1; i++) cyc(1);
      chk(cev, 1'b1);
   endtask : wait_ev
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #1000000;
      bad_count++;
      conclude();
   end
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      {rst, vld, gctl, cfg_v, cfg_val, txw, syncp, card, rdy} = 9'h100;
      {cpin, ccode, gset, cfg_item, gpo} = '0;
      net = NS_NONE;
      bad_count = 0;
      check_count = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      cyc(2);
      chk(pin_oe[0], 1'b0); chk(pin_pd[0], 1'b1); chk(pin_oe[1], 1'b1); chk(pin_out[1], 1'b0);
      chk(pin_pd[2], 1'b1); chk(pin_oe[3], 1'b1); chk(pin_out[3], 1'b0); chk(pin_pd[4], 1'b1);
      chk(pin_oe[4], 1'b0); chk(hp, 1'b0); $display("test reset done");
      cmd(PIN2, FN_TX_BURST, 1'b0);
      cmd(PIN1, FN_TX_BURST, 1'b1);
      @(posedge clk) txw <= 1'b1;
      cyc(3); chk(pin_out[0], 1'b1);
      @(posedge clk) txw <= 1'b0;
      cyc(TX_TRAIL_CYC - 5); chk(pin_out[0], 1'b1);
      cyc(10); chk(pin_out[0], 1'b0); $display("test burst done");
      cmd(PIN1, FN_GNSS_SUPPLY, 1'b0);
      cmd(PIN2, FN_OUTPUT, 1'b1);
      cmd(PIN1, FN_GNSS_SUPPLY, 1'b1);
      cmd(PIN3, FN_GNSS_SUPPLY, 1'b0);
      @(posedge clk) begin
         gctl <= 1'b1;
         gpo <= 5'h02;
      end
      cyc(3); chk(pin_out[0], 1'b1); chk(pin_out[1], 1'b1); $display("test supply done");
      @(posedge clk) begin
         gset <= GSET_READY;
         rdy <= 1'b1;
      end
      cyc(3); chk(wake, 1'b1);
      @(posedge clk) begin
         gset <= GSET_SYNC;
         syncp <= 1'b1;
      end
      cyc(3); chk(wake, 1'b0); chk(pin_pd[2], 1'b1); chk(pin_out[3], 1'b1);
      @(posedge clk) syncp <= 1'b0;
      cyc(3); chk(pin_out[3], 1'b0); $display("test gnss done");
      cmd(PIN3, FN_NETSTAT, 1'b1);
      cmd(PIN4, FN_NETSTAT, 1'b0);
      for (int s = 1; s < 6; s++) begin
         @(posedge clk) net <= NS_NONE;
         cyc(4); chk(pin_out[2], 1'b0);
         @(posedge clk) net <= pfs_net_t'(s);
         cyc(4); chk(pin_out[2], 1'b1);
      end
      $display("test netstat done");
      @(posedge clk) card <= 1'b1;
      wait_ev(); chk(card_o, 1'b1);
      @(posedge clk) card <= 1'b0;
      wait_ev(); chk(card_o, 1'b0); $display("test card done");
      // other item ignored, item 50 enables, item 50 with value 0 disables again
      for (int k = 0; k < 3; k++) begin
         @(posedge clk) begin
            cfg_v <= 1'b1;
            cfg_val <= (k != 2);
            cfg_item <= k ? CFG_HOTPLUG_ITEM : 8'h31;
         end
         @(posedge clk) cfg_v <= 1'b0;
         cyc(2); chk(hp, k == 1);
      end
      cmd(3'h5, FN_OUTPUT, 1'b0);
      cmd(PIN1, FN_GNSS_READY, 1'b0);
      cmd(PIN5, FN_TIME_SYNC, 1'b0);
      cmd(PIN1, FN_CARD_DETECT, 1'b0);
      cmd(PIN5, FN_INPUT, 1'b1);
      cmd(PIN2, 8'h06, 1'b0);
      cmd(PIN1, FN_PAD_OFF, 1'b1);
      @(posedge clk) card <= 1'b1;
      cyc(4); chk(gp_in[4], 1'b1);
      chk(pin_oe[0], 1'b0);
      chk(pin_pd[0], 1'b1); $display("test codes done");
      // second reset in mid-run: defaults return, a card already present shows as a change
      @(posedge clk) rst <= 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      cyc(2);
      chk(pin_oe[0], 1'b0);
      chk(pin_pd[0], 1'b1);
      chk(pin_oe[1], 1'b1);
      chk(pin_out[1], 1'b1);
      chk(pin_pd[4], 1'b1);
      chk(card_o, 1'b1);
      chk(hp, 1'b0);
      cmd(PIN4, FN_NETSTAT, 1'b1);
      $display("test second reset done");
      conclude();
   end
endmodule : pfs_top_tb_top
bind pfs_top pfs_top_chk u_pfs_top_chk (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .CMD_VALID_I(CMD_VALID_I),
   .CMD_PIN_I(CMD_PIN_I), .CMD_CODE_I(CMD_CODE_I), .CMD_ACCEPT_O(CMD_ACCEPT_O), .CMD_REJECT_O(CMD_REJECT_O),
   .GNSS_CTRL_I(GNSS_CTRL_I), .GNSS_PIN_SET_I(GNSS_PIN_SET_I), .GNSS_WAKE_O(GNSS_WAKE_O),
   .CARD_PRESENT_O(CARD_PRESENT_O), .CARD_EVENT_O(CARD_EVENT_O));
